// ### hw/vmon_channel_config.sv
// Voltage-monitor channel configuration, result post-processing and threshold check
`timescale 1ns/10ps
// Notes on behaviour
// (RULE_01) Eight inputs in full variant; reduced variant uses only inputs one to six.
// (RULE_02) Two-bit range code: 00 5.6V, 01 2.8V, 10 1.4V, 11 reserved.
// (RULE_03) Range fields of inputs 1-4 in first register, 5-8 in second.
// (RULE_04) Enable register bit n-1 enables monitoring of input n.
// (RULE_05) Each input has two undervoltage and two overvoltage limits.
// (RULE_06) Every threshold register is eight bits wide.
// (RULE_07) Only the upper eight result bits are compared against limits.
// (RULE_08) Pseudo-differential result is first single-ended code minus second.
// (RULE_09) Unipolar pairs accept only positive differences; bipolar pairs both signs.
// (RULE_10) Bipolar results are two's complement over the full code width.
// (RULE_11) Single-ended conversions are unipolar regardless of polarity bits.
// (RULE_12) Single-ended code is input over range times 1024, integer part.
// (RULE_13) Mode bits 3:0 pick single-ended or pseudo-differential per pair.
// (RULE_14) Mode bits 7:4 pick unipolar or bipolar per pair.
// (RULE_15) Compare stored results after each full multiplexer cycle; violations fault.
// (RULE_16) Disabled inputs never raise undervoltage or overvoltage faults.
// (RULE_17) Software never writes reserved range code 11.
module vmon_channel_config #(
	parameter bit FULL_VARIANT = 1'b1
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Register port from the serial interface or boot copy
	input wire vmon_pkg::reg_req_t REG_REQ,
	output logic [vmon_pkg::DATA_W-1:0] REG_RDATA,
	// Single-ended codes from the converter, one input per stop
	input wire logic CONV_VALID,
	input wire logic [2:0] CONV_INDEX,
	input wire logic [vmon_pkg::CODE_W-1:0] CONV_CODE,
	input wire logic MUX_CYCLE_DONE,
	// Range steering for the analog front end
	output logic [2*vmon_pkg::NUM_INPUTS-1:0] RANGE_SEL,
	output logic [vmon_pkg::NUM_INPUTS-1:0] INPUT_ACTIVE,
	// Fault results
	output vmon_pkg::fault_vec_t FAULTS,
	output logic COMPARE_DONE
);
	import vmon_pkg::*;

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [7:0] range_lo_ff;
	logic [7:0] range_hi_ff;
	logic [7:0] mon_en_ff;
	logic [7:0] mode_ff;
	logic [THR_W-1:0] thr_ff [0:4*NUM_INPUTS-1];
	logic [CODE_W-1:0] se_code_ff [0:NUM_INPUTS-1];
	logic [CODE_W-1:0] result_ff [0:NUM_INPUTS-1];
	fault_vec_t fault_ff;
	logic done_ff;
	logic [NUM_INPUTS-1:0] present;

	// Reduced variant has no inputs seven and eight
	assign present = FULL_VARIANT ? 8'hFF : 8'h3F; // RULE_01

	function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
		input logic [7:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// Threshold slot of an address inside the threshold window
	function automatic logic [4:0] thr_slot(input logic [7:0] a);
		thr_slot = 5'(a - THR_BASE_OFS);
	endfunction

	// Upper bits of a code, the only part compared or read back
	function automatic logic [THR_W-1:0] upper_bits(input logic [CODE_W-1:0] c);
		upper_bits = c[CODE_W-1 -: THR_W];
	endfunction

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			range_lo_ff <= RANGE_RST;
			range_hi_ff <= RANGE_RST;
			mon_en_ff <= MON_EN_RST;
			mode_ff <= MODE_RST;
		end else if (REG_REQ.wr) begin
			if (REG_REQ.addr == RANGE_LO_OFS) begin
				range_lo_ff <= REG_REQ.wdata; // RULE_03
			end else if (REG_REQ.addr == RANGE_HI_OFS) begin
				range_hi_ff <= REG_REQ.wdata; // RULE_03
			end else if (REG_REQ.addr == MON_EN_OFS) begin
				mon_en_ff <= REG_REQ.wdata; // RULE_04
			end else if (REG_REQ.addr == MODE_OFS) begin
				mode_ff <= REG_REQ.wdata; // RULE_13
			end
		end
	end

	// Four eight-bit limits per input
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < 4*NUM_INPUTS; i++) begin
				thr_ff[i] <= THR_RST;
			end
		end else if (REG_REQ.wr && in_range(REG_REQ.addr, THR_BASE_OFS, THR_LAST_OFS)) begin
			thr_ff[thr_slot(REG_REQ.addr)] <= REG_REQ.wdata; // RULE_05 RULE_06
		end
	end

	// Range code 11 is passed through unchanged; its use is the host's fault
	assign RANGE_SEL = {range_hi_ff, range_lo_ff}; // RULE_02 RULE_12 RULE_17
	assign INPUT_ACTIVE = mon_en_ff & present;

	// ----------------------------------------
	// Result capture and pair post-processing
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < NUM_INPUTS; i++) begin
				se_code_ff[i] <= '0;
			end
		end else if (CONV_VALID && present[CONV_INDEX]) begin
			se_code_ff[CONV_INDEX] <= CONV_CODE; // RULE_12
		end
	end

	genvar p;
	generate
		for (p = 0; p < NUM_INPUTS/2; p++) begin : g_pair
			logic [CODE_W:0] diff;
			logic diff_mode;
			logic bip;
			assign diff = {1'b0, se_code_ff[2*p]} - {1'b0, se_code_ff[2*p+1]}; // RULE_08
			assign diff_mode = mode_ff[MODE_DIFF_LSB+p]; // RULE_13
			assign bip = mode_ff[MODE_BIP_LSB+p]; // RULE_14
			always_ff @(posedge CLK or posedge RST) begin
				if (RST) begin
					result_ff[2*p] <= '0;
					result_ff[2*p+1] <= '0;
				end else if (!diff_mode) begin
					// Polarity bits ignored in single-ended mode
					result_ff[2*p] <= se_code_ff[2*p]; // RULE_11
					result_ff[2*p+1] <= se_code_ff[2*p+1]; // RULE_11
				end else begin
					if (bip) begin
						result_ff[2*p] <= diff[CODE_W-1:0]; // RULE_09 RULE_10
					end else begin
						// Negative differences clamp to zero in unipolar form
						result_ff[2*p] <= diff[CODE_W] ? '0 : diff[CODE_W-1:0]; // RULE_09
					end
					result_ff[2*p+1] <= '0;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Threshold comparison after each mux cycle
	// ----------------------------------------
	fault_vec_t nxt_fault;
	always_comb begin
		logic [THR_W-1:0] top;
		logic sgn;
		top = '0;
		sgn = 1'b0;
		nxt_fault = '0;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			top = upper_bits(result_ff[i]); // RULE_07
			// Signed compare only for bipolar pseudo-differential pairs
			sgn = mode_ff[MODE_DIFF_LSB+i/2] && mode_ff[MODE_BIP_LSB+i/2];
			if (mon_en_ff[i] && present[i]) begin // RULE_16
				if (sgn) begin
					nxt_fault.puv[i] = $signed(top) < $signed(thr_ff[4*i+THR_PUV]);
					nxt_fault.suv[i] = $signed(top) < $signed(thr_ff[4*i+THR_SUV]);
					nxt_fault.pov[i] = $signed(top) > $signed(thr_ff[4*i+THR_POV]);
					nxt_fault.sov[i] = $signed(top) > $signed(thr_ff[4*i+THR_SOV]);
				end else begin
					nxt_fault.puv[i] = top < thr_ff[4*i+THR_PUV];
					nxt_fault.suv[i] = top < thr_ff[4*i+THR_SUV];
					nxt_fault.pov[i] = top > thr_ff[4*i+THR_POV];
					nxt_fault.sov[i] = top > thr_ff[4*i+THR_SOV];
				end
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			fault_ff <= '0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= MUX_CYCLE_DONE;
			// Result registers settle one cycle after the last stop
			if (done_ff) begin
				fault_ff <= nxt_fault; // RULE_15
			end
		end
	end

	assign FAULTS = fault_ff;
	assign COMPARE_DONE = done_ff;

	// ----------------------------------------
	// Read-back
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			REG_RDATA <= '0;
		end else if (REG_REQ.rd) begin
			if (REG_REQ.addr == RANGE_LO_OFS) begin
				REG_RDATA <= range_lo_ff;
			end else if (REG_REQ.addr == RANGE_HI_OFS) begin
				REG_RDATA <= range_hi_ff;
			end else if (REG_REQ.addr == MON_EN_OFS) begin
				REG_RDATA <= mon_en_ff;
			end else if (REG_REQ.addr == MODE_OFS) begin
				REG_RDATA <= mode_ff;
			end else if (in_range(REG_REQ.addr, THR_BASE_OFS, THR_LAST_OFS)) begin
				REG_RDATA <= thr_ff[thr_slot(REG_REQ.addr)];
			end else if (in_range(REG_REQ.addr, RESULT_BASE_OFS, RESULT_LAST_OFS)) begin
				REG_RDATA <= upper_bits(result_ff[3'(REG_REQ.addr - RESULT_BASE_OFS)]);
			end else if (in_range(REG_REQ.addr, FAULT_OFS, FAULT_LAST_OFS)) begin
				REG_RDATA <= fault_ff[8*(3-int'(REG_REQ.addr[1:0])) +: 8];
			end else begin
				REG_RDATA <= '0;
			end
		end
	end
endmodule

// ### hw/vmon_pkg.sv
// Package: register map, field layout and types of the voltage-monitor channel block
package vmon_pkg;
	localparam int NUM_INPUTS = 8;
	localparam int NUM_INPUTS_REDUCED = 6;
	localparam int CODE_W = 10;
	localparam int THR_W = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	// Register offsets
	localparam logic [7:0] RANGE_LO_OFS = 8'h17;
	localparam logic [7:0] RANGE_HI_OFS = 8'h18;
	localparam logic [7:0] MON_EN_OFS = 8'h1A;
	localparam logic [7:0] MODE_OFS = 8'h1C;
	localparam logic [7:0] THR_BASE_OFS = 8'h20;
	localparam logic [7:0] THR_LAST_OFS = 8'h3F;
	localparam logic [7:0] RESULT_BASE_OFS = 8'h40;
	localparam logic [7:0] FAULT_OFS = 8'h50;
	localparam logic [7:0] RESULT_LAST_OFS = 8'h47;
	localparam logic [7:0] FAULT_LAST_OFS = 8'h53;
	// Reset values (all configuration clears at power-on)
	localparam logic [7:0] RANGE_RST = 8'h00;
	localparam logic [7:0] MON_EN_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] THR_RST = 8'h00;
	// Mode register field positions
	localparam int MODE_DIFF_LSB = 0;
	localparam int MODE_BIP_LSB = 4;
	// Threshold order inside one input's group of four
	localparam int THR_PUV = 0;
	localparam int THR_SUV = 1;
	localparam int THR_POV = 2;
	localparam int THR_SOV = 3;
	typedef enum logic [1:0] {
		RANGE_5V6 = 2'b00,
		RANGE_2V8 = 2'b01,
		RANGE_1V4 = 2'b10,
		RANGE_RSVD = 2'b11
	} range_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;
	typedef struct packed {
		logic [NUM_INPUTS-1:0] puv;
		logic [NUM_INPUTS-1:0] suv;
		logic [NUM_INPUTS-1:0] pov;
		logic [NUM_INPUTS-1:0] sov;
	} fault_vec_t;
endpackage

// ### bench/vmon_checker.sv
// Port-level assertions for the voltage-monitor channel block
`timescale 1ns/10ps
module vmon_checker
	import vmon_pkg::*;
#(
	parameter bit FULL_VARIANT = 1'b1
) (
	input wire logic CLK,
	input wire logic RST,
	input wire vmon_pkg::reg_req_t REG_REQ,
	input wire logic [7:0] REG_RDATA,
	input wire logic MUX_CYCLE_DONE,
	input wire logic [15:0] RANGE_SEL,
	input wire logic [7:0] INPUT_ACTIVE,
	input wire vmon_pkg::fault_vec_t FAULTS,
	input wire logic COMPARE_DONE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	AST_CMP_FOLLOWS: assert property (MUX_CYCLE_DONE |=> COMPARE_DONE)
		else $error("compare missing");
	AST_CMP_CAUSE: assert property (COMPARE_DONE |-> $past(MUX_CYCLE_DONE))
		else $error("compare without mux cycle");
	// Faults may only move on the edge after a compare
	AST_FAULT_HOLD: assert property (!$past(COMPARE_DONE) |-> $stable(FAULTS))
		else $error("faults moved");
	AST_DIS_NOFAULT: assert property ($past(COMPARE_DONE) |-> ((FAULTS.puv | FAULTS.suv |
		FAULTS.pov | FAULTS.sov) & ~$past(INPUT_ACTIVE)) == 8'h00) else $error("disabled fault");
	AST_RANGE_LO: assert property (REG_REQ.wr && REG_REQ.addr == RANGE_LO_OFS
		|=> RANGE_SEL[7:0] == $past(REG_REQ.wdata)) else $error("range lo");
	AST_RANGE_HI: assert property (REG_REQ.wr && REG_REQ.addr == RANGE_HI_OFS
		|=> RANGE_SEL[15:8] == $past(REG_REQ.wdata)) else $error("range hi");
	AST_EN_WR: assert property (REG_REQ.wr && REG_REQ.addr == MON_EN_OFS |=>
		INPUT_ACTIVE == ($past(REG_REQ.wdata) & (FULL_VARIANT ? 8'hFF : 8'h3F))) else $error("enable");
	AST_RD_RANGE: assert property (REG_REQ.rd && REG_REQ.addr == RANGE_LO_OFS
		|=> REG_RDATA == $past(RANGE_SEL[7:0])) else $error("range readback");
endmodule
bind vmon_channel_config vmon_checker #(.FULL_VARIANT(FULL_VARIANT)) chk (.CLK(CLK), .RST(RST),
	.REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .MUX_CYCLE_DONE(MUX_CYCLE_DONE),
	.RANGE_SEL(RANGE_SEL), .INPUT_ACTIVE(INPUT_ACTIVE), .FAULTS(FAULTS), .COMPARE_DONE(COMPARE_DONE));

// ### bench/vmon_rail_model.sv
// Behavioural supply rails and converter: one code per input, then a cycle-done pulse
`timescale 1ns/10ps
module vmon_rail_model (
	input wire logic clk,
	input wire logic start,
	input int mv [8],
	input wire logic [15:0] range_sel,
	output logic conv_valid = 1'b0,
	output logic [2:0] conv_index = 3'h0,
	output logic [9:0] conv_code = 10'h000,
	output logic mux_done = 1'b0
);
	int full;
	always @(posedge clk) begin
		if (start) begin
			for (int i = 0; i < 8; i++) begin
				full = range_sel[2*i+:2] == 2'b00 ? 5600 : range_sel[2*i+:2] == 2'b01 ? 2800 : 1400;
				conv_valid <= 1'b1;
				conv_index <= 3'(i);
				conv_code <= 10'(mv[i] * 1024 / full > 1023 ? 1023 : mv[i] * 1024 / full);
				@(posedge clk);
			end
			conv_valid <= 1'b0;
			// Stale code is inverted so nothing can lean on it
			conv_code <= ~conv_code;
			mux_done <= 1'b1;
			@(posedge clk);
			mux_done <= 1'b0;
		end
	end
endmodule

// ### bench/tb_top.sv
// Register and conversion sequences for the voltage-monitor channel block
`timescale 1ns/10ps
module tb_top;
	import vmon_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	reg_req_t req = '0;
	logic [7:0] rdata, active, active_reduced;
	logic cvalid, mdone, cdone;
	logic [2:0] cidx;
	logic [9:0] ccode;
	logic [15:0] rsel;
	fault_vec_t faults;
	int mv [8] = '{2000, 2000, 1000, 0, 0, 0, 0, 0};
	logic [7:0] modes [3] = '{8'h11, 8'h01, 8'h10};
	logic [7:0] dexp [3] = '{8'hA4, 8'h00, 8'h5B};
	logic [7:0] pexp [3] = '{8'h00, 8'h00, 8'h03};
	int num_errors = 0;
	int n_compared = 0;
	always #5 clk = ~clk;
	vmon_channel_config #(.FULL_VARIANT(1'b1)) dut (.CLK(clk), .RST(rst), .REG_REQ(req),
		.REG_RDATA(rdata), .CONV_VALID(cvalid), .CONV_INDEX(cidx), .CONV_CODE(ccode),
		.MUX_CYCLE_DONE(mdone), .RANGE_SEL(rsel), .INPUT_ACTIVE(active), .FAULTS(faults),
		.COMPARE_DONE(cdone));
	// Six-input variant shares the bus and converter stream
	vmon_channel_config #(.FULL_VARIANT(1'b0)) dut_reduced (.CLK(clk), .RST(rst), .REG_REQ(req),
		.REG_RDATA(), .CONV_VALID(cvalid), .CONV_INDEX(cidx), .CONV_CODE(ccode),
		.MUX_CYCLE_DONE(mdone), .RANGE_SEL(), .INPUT_ACTIVE(active_reduced), .FAULTS(),
		.COMPARE_DONE());
	vmon_rail_model rails (.clk(clk), .start(start), .mv(mv), .range_sel(rsel),
		.conv_valid(cvalid), .conv_index(cidx), .conv_code(ccode), .mux_done(mdone));
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
		#1 chk8(rdata, e);
	endtask
	// Faults settle one edge after the compare pulse
	task automatic mux_cycle();
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		for (int i = 0; i < 40 && cdone !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (cdone !== 1'b1) begin
			num_errors++;
			$display("Error at %0t: no compare", $time);
			final_report();
		end
		@(posedge clk);
		#1;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(RANGE_LO_OFS, RANGE_RST);
		rd(MON_EN_OFS, MON_EN_RST);
		wr(RANGE_LO_OFS, 8'h24);
		wr(RANGE_HI_OFS, 8'h06);
		wr(MON_EN_OFS, 8'hC3);
		rd(RANGE_LO_OFS, 8'h24);
		chk8(rsel[15:8], 8'h06);
		chk8(active, 8'hC3);
		chk8(active_reduced, 8'h03);
		rd(8'h10, 8'h00);
		wr(THR_BASE_OFS, 8'h60);
		wr(THR_BASE_OFS + 8'(THR_SOV), 8'hFF);
		mux_cycle();
		rd(RESULT_BASE_OFS, 8'h5B);
		rd(RESULT_BASE_OFS + 8'h01, 8'hB6);
		chk8(faults.puv, 8'h01);
		chk8(faults.pov, 8'h03);
		chk8(faults.suv, 8'h00);
		chk8(faults.sov, 8'h02);
		$display("test single-ended done");
		foreach (modes[k]) begin
			wr(MODE_OFS, modes[k]);
			mux_cycle();
			rd(RESULT_BASE_OFS, dexp[k]);
			chk8(faults.pov, pexp[k]);
		end
		rd(RESULT_BASE_OFS + 8'h01, 8'hB6);
		$display("test modes done");
		final_report();
	end
endmodule
